// *** include/cks_pkg.sv ***
package cks_pkg;

  // register word offsets on the bus
  localparam logic [11:0] CKS_OFS_CTRL   = 12'h000;
  localparam logic [11:0] CKS_OFS_CTRL_B = 12'h004;
  localparam logic [11:0] CKS_OFS_TUNE   = 12'h008;
  localparam logic [11:0] CKS_OFS_STAT   = 12'h00C;

  // osc_control_reg fields
  localparam int CKS_CTRL_IDLE_BIT = 7;
  localparam int CKS_CTRL_FREQ_LSB = 4;
  localparam int CKS_CTRL_SEL_LSB  = 0;
  // osc_control_reg_b fields
  localparam int CKS_CTRLB_MED_BIT = 4;
  localparam int CKS_CTRLB_DRV_BIT = 2;
  // tuning_register fields
  localparam int CKS_TUNE_SRC_BIT  = 7;
  localparam int CKS_TUNE_PLL_BIT  = 6;
  localparam int CKS_TUNE_TRIM_LSB = 0;
  // status fields
  localparam int CKS_STAT_PRI_BIT  = 0;
  localparam int CKS_STAT_SEC_BIT  = 1;
  localparam int CKS_STAT_PLL_BIT  = 2;
  localparam int CKS_STAT_FAIL_BIT = 3;
  localparam int CKS_STAT_BUSY_BIT = 4;
  // primary_config_word fields
  localparam int CKS_CFG_PLL_BIT   = 4;
  localparam int CKS_CFG_PRIEN_BIT = 5;

  // values after reset
  localparam logic [1:0] CKS_SEL_RST  = 2'h0;
  localparam logic [2:0] CKS_FREQ_RST = 3'h3;
  localparam logic       CKS_DRV_RST  = 1'b1;

  // primary mode encodings
  localparam logic [3:0] CKS_FOSC_INT_LO = 4'h8;
  localparam logic [3:0] CKS_FOSC_INT_HI = 4'h9;

  // counts
  localparam logic [2:0] CKS_FAIL_WINDOW = 3'h4;
  localparam logic [1:0] CKS_CLKOUT_HALF = 2'h3;
  localparam logic [9:0] CKS_HF_TUNE_TERM = 10'h1FF;
  localparam logic [9:0] CKS_MF_TUNE_TERM = 10'h00F;

  typedef enum logic [1:0] {CKS_SRC_PRI, CKS_SRC_SEC, CKS_SRC_INT} cks_src_t;
  typedef enum logic [1:0] {CKS_RUN, CKS_DROP, CKS_ARM, CKS_RISE} cks_sw_state_t;

endpackage

// *** src/cks_clock_selector.sv ***
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cks_clock_selector
  import cks_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [7:0]  primary_config_word_in,
  input  wire logic        pri_osc_tick_in,
  input  wire logic        pll_tick_in,
  input  wire logic        sec_tick_in,
  input  wire logic        hf_tick_in,
  input  wire logic        mf_tick_in,
  input  wire logic        lf_tick_in,
  input  wire logic        sleep_req_in,
  input  wire logic        wake_in,
  output logic             sys_clk_out,
  output logic             sys_tick_out,
  output logic             wdt_tick_out,
  output logic             sleep_out,
  output logic             idle_out,
  output logic             clock_out_pin_out,
  output logic             clock_out_pin_oe_out,
  output logic             pll_select_out,
  output logic             pri_drive_on_out,
  output logic             clock_fail_out
);

  function automatic logic cks_div_hit(input logic [8:0] cnt, input logic [3:0] k);
    logic [8:0] mask;
    mask = 9'(({9'h000, 1'b1} << k) - 10'h001);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic [9:0] cks_tune_limit(input logic [9:0] base, input logic [5:0] trim);
    logic [10:0] sum;
    sum = {1'b0, base} + {{5{trim[5]}}, trim};
    if (sum[10] || sum[9:0] == 10'h000) begin
      return 10'h001;
    end
    return sum[9:0];
  endfunction

  function automatic logic cks_src_tick(input cks_src_t s, input logic p, input logic q, input logic i);
    case (s)
      CKS_SRC_PRI: return p;
      CKS_SRC_SEC: return q;
      default:     return i;
    endcase
  endfunction

  function automatic logic cks_is_internal(input logic [3:0] f);
    return f == CKS_FOSC_INT_LO || f == CKS_FOSC_INT_HI;
  endfunction

  // encodings with clock out: external clock 0100/1010/1100/1110, RC 0110, internal 1001
  function automatic logic cks_clkout_mode(input logic [3:0] f);
    return f == 4'h4 || f == 4'h6 || f == 4'h9 || f == 4'hA || f == 4'hC || f == 4'hE;
  endfunction

  // ---------------- registers ----------------
  logic       idle_on_sleep, next_idle_on_sleep;
  logic [2:0] internal_freq_select, next_internal_freq_select;
  logic [1:0] system_clock_select, next_system_clock_select;
  logic       medium_osc_select, next_medium_osc_select;
  logic       primary_drive_shutdown, next_primary_drive_shutdown;
  logic       low_freq_source_select, next_low_freq_source_select;
  logic       pll_soft_enable, next_pll_soft_enable;
  logic [5:0] trim_value, next_trim_value;
  logic       fail_flag, next_fail_flag;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;

  logic       wr_en, rd_access, addr_ok, fail_event;
  cks_src_t   cur_src, next_cur_src, pend_src, next_pend_src;
  cks_src_t   tgt, tgt_s1, tgt_s2;
  cks_sw_state_t sw_state, next_sw_state;

  assign rd_access = psel_in && penable_in && !pready_out;
  assign wr_en     = psel_in && penable_in && pready_out && pwrite_in;
  assign addr_ok   = paddr_in == CKS_OFS_CTRL || paddr_in == CKS_OFS_CTRL_B ||
                     paddr_in == CKS_OFS_TUNE || paddr_in == CKS_OFS_STAT;

  always_comb begin
    next_idle_on_sleep          = idle_on_sleep;
    next_internal_freq_select   = internal_freq_select;
    next_system_clock_select    = system_clock_select;
    next_medium_osc_select      = medium_osc_select;
    next_primary_drive_shutdown = primary_drive_shutdown;
    next_low_freq_source_select = low_freq_source_select;
    next_pll_soft_enable        = pll_soft_enable;
    next_trim_value             = trim_value;
    next_fail_flag              = fail_flag;
    if (wr_en) begin
      if (paddr_in == CKS_OFS_CTRL) begin
        next_idle_on_sleep        = pwdata_in[CKS_CTRL_IDLE_BIT];
        next_internal_freq_select = pwdata_in[CKS_CTRL_FREQ_LSB +: 3];
        next_system_clock_select  = pwdata_in[CKS_CTRL_SEL_LSB +: 2];
      end else if (paddr_in == CKS_OFS_CTRL_B) begin
        next_medium_osc_select      = pwdata_in[CKS_CTRLB_MED_BIT];
        next_primary_drive_shutdown = pwdata_in[CKS_CTRLB_DRV_BIT];
      end else if (paddr_in == CKS_OFS_TUNE) begin
        next_low_freq_source_select = pwdata_in[CKS_TUNE_SRC_BIT];
        next_pll_soft_enable        = pwdata_in[CKS_TUNE_PLL_BIT];
        next_trim_value             = pwdata_in[CKS_TUNE_TRIM_LSB +: 6];
      end else if (paddr_in == CKS_OFS_STAT && pwdata_in[CKS_STAT_FAIL_BIT]) begin
        next_fail_flag = 1'b0;
      end
    end
    // a loss detected in the clearing cycle still sets the flag
    if (fail_event) begin
      next_fail_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      idle_on_sleep          <= 1'b0;
      internal_freq_select   <= CKS_FREQ_RST;
      system_clock_select    <= CKS_SEL_RST;
      medium_osc_select      <= 1'b0;
      primary_drive_shutdown <= CKS_DRV_RST;
      low_freq_source_select <= 1'b0;
      pll_soft_enable        <= 1'b0;
      trim_value             <= 6'h00;
      fail_flag              <= 1'b0;
    end else begin
      idle_on_sleep          <= next_idle_on_sleep;
      internal_freq_select   <= next_internal_freq_select;
      system_clock_select    <= next_system_clock_select;
      medium_osc_select      <= next_medium_osc_select;
      primary_drive_shutdown <= next_primary_drive_shutdown;
      low_freq_source_select <= next_low_freq_source_select;
      pll_soft_enable        <= next_pll_soft_enable;
      trim_value             <= next_trim_value;
      fail_flag              <= next_fail_flag;
    end
  end

  // ---------------- bus answer: one wait state, then pready ----------------
  always_comb begin
    next_pready  = rd_access;
    next_pslverr = rd_access && !addr_ok;
    next_prdata  = 32'h0000_0000;
    if (rd_access && !pwrite_in) begin
      if (paddr_in == CKS_OFS_CTRL) begin
        next_prdata[CKS_CTRL_IDLE_BIT]      = idle_on_sleep;
        next_prdata[CKS_CTRL_FREQ_LSB +: 3] = internal_freq_select;
        next_prdata[CKS_CTRL_SEL_LSB +: 2]  = system_clock_select;
      end else if (paddr_in == CKS_OFS_CTRL_B) begin
        next_prdata[CKS_CTRLB_MED_BIT] = medium_osc_select;
        next_prdata[CKS_CTRLB_DRV_BIT] = primary_drive_shutdown;
      end else if (paddr_in == CKS_OFS_TUNE) begin
        next_prdata[CKS_TUNE_SRC_BIT]       = low_freq_source_select;
        next_prdata[CKS_TUNE_PLL_BIT]       = pll_soft_enable;
        next_prdata[CKS_TUNE_TRIM_LSB +: 6] = trim_value;
      end else if (paddr_in == CKS_OFS_STAT) begin
        next_prdata[CKS_STAT_PRI_BIT]  = cur_src == CKS_SRC_PRI && !cks_is_internal(primary_config_word_in[3:0]);
        next_prdata[CKS_STAT_SEC_BIT]  = cur_src == CKS_SRC_SEC;
        next_prdata[CKS_STAT_PLL_BIT]  = cur_src == CKS_SRC_PRI && pll_select_out;
        next_prdata[CKS_STAT_FAIL_BIT] = fail_flag;
        next_prdata[CKS_STAT_BUSY_BIT] = sw_state != CKS_RUN;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out  <= next_prdata;
    end
  end

  // ---------------- internal block: postscaler, medium divider, tuned divider ----------------
  logic [8:0] hf_cnt;
  logic [3:0] mf_cnt;
  logic [9:0] tn_cnt, tn_limit;
  logic       tn_src, tn_hit, int_tick, pll_sel, pri_tick, fosc_int;
  logic [3:0] fosc;

  assign fosc     = primary_config_word_in[3:0];
  assign fosc_int = cks_is_internal(fosc);
  assign tn_src   = medium_osc_select ? mf_tick_in : hf_tick_in;
  assign tn_limit = cks_tune_limit(medium_osc_select ? CKS_MF_TUNE_TERM : CKS_HF_TUNE_TERM, trim_value);
  assign tn_hit   = tn_src && tn_cnt == tn_limit;

  always_comb begin
    int_tick = 1'b0;
    case (internal_freq_select)
      3'h2: int_tick = medium_osc_select ? mf_tick_in : hf_tick_in && cks_div_hit(hf_cnt, 4'h5);
      3'h1: int_tick = medium_osc_select ? mf_tick_in && mf_cnt[0] : hf_tick_in && cks_div_hit(hf_cnt, 4'h6);
      3'h0: int_tick = low_freq_source_select ? tn_hit : lf_tick_in;
      default: int_tick = hf_tick_in && cks_div_hit(hf_cnt, 4'(3'h7 - internal_freq_select));
    endcase
  end

  // pll path: encodings with bit 3 clear follow the fuse, those with bit 3 set follow the soft enable
  assign pll_sel  = fosc[3] ? pll_soft_enable : primary_config_word_in[CKS_CFG_PLL_BIT];
  assign pri_tick = fosc_int ? (pll_sel ? pll_tick_in : int_tick) :
                    (primary_config_word_in[CKS_CFG_PRIEN_BIT] && primary_drive_shutdown &&
                     (pll_sel ? pll_tick_in : pri_osc_tick_in));

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hf_cnt <= 9'h000;
      mf_cnt <= 4'h0;
      tn_cnt <= 10'h000;
    end else begin
      hf_cnt <= hf_tick_in ? 9'(hf_cnt + 9'h001) : hf_cnt;
      mf_cnt <= mf_tick_in ? 4'(mf_cnt + 4'h1) : mf_cnt;
      tn_cnt <= tn_hit || tn_cnt > tn_limit ? 10'h000 : (tn_src ? 10'(tn_cnt + 10'h001) : tn_cnt);
    end
  end

  // ---------------- fail monitor, counted on the low oscillator ----------------
  logic       pri_seen, next_pri_seen;
  logic [2:0] miss_cnt, next_miss_cnt;
  logic       fail_s1, fail_s2;

  always_comb begin
    next_pri_seen = pri_seen || pri_osc_tick_in;
    next_miss_cnt = miss_cnt;
    fail_event    = 1'b0;
    if (fosc_int || cur_src != CKS_SRC_PRI || fail_flag) begin
      next_miss_cnt = 3'h0;
    end else if (lf_tick_in) begin
      next_pri_seen = pri_osc_tick_in;
      next_miss_cnt = pri_seen ? 3'h0 : 3'(miss_cnt + 3'h1);
      fail_event    = !pri_seen && miss_cnt == CKS_FAIL_WINDOW - 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pri_seen <= 1'b0;
      miss_cnt <= 3'h0;
    end else begin
      pri_seen <= next_pri_seen;
      miss_cnt <= next_miss_cnt;
    end
  end

  // ---------------- source switch ----------------
  always_comb begin
    if (fail_flag) begin
      tgt = CKS_SRC_INT;
    end else if (system_clock_select[1]) begin
      tgt = CKS_SRC_INT;
    end else if (system_clock_select[0]) begin
      tgt = CKS_SRC_SEC;
    end else begin
      tgt = CKS_SRC_PRI;
    end
  end

  logic cur_tick, new_tick, next_sys_clk, next_sys_tick;
  logic next_sleep, next_idle, next_clkout, next_clkout_oe;
  logic [1:0] co_cnt, next_co_cnt;

  assign cur_tick = cks_src_tick(cur_src, pri_tick, sec_tick_in, int_tick);
  assign new_tick = cks_src_tick(pend_src, pri_tick, sec_tick_in, int_tick);

  always_comb begin
    next_sw_state = sw_state;
    next_cur_src  = cur_src;
    next_pend_src = pend_src;
    next_sys_clk  = sys_clk_out;
    case (sw_state)
      CKS_RUN: begin
        // sleep or a pending switch lets the clock fall but never rise, so no short high pulse follows
        if (cur_tick && (sys_clk_out || (!sleep_out && tgt_s2 == cur_src))) begin
          next_sys_clk = !sys_clk_out;
        end
        if (tgt_s2 != cur_src) begin
          next_pend_src = tgt_s2;
          next_sw_state = CKS_DROP;
        end
      end
      CKS_DROP: begin
        // a dead old clock cannot be waited on, so failure forces it low
        if (!sys_clk_out || fail_s2 || cur_tick) begin
          next_sys_clk  = 1'b0;
          next_sw_state = CKS_ARM;
        end
      end
      CKS_ARM: begin
        if (new_tick) begin
          next_sw_state = CKS_RISE;
        end
      end
      default: begin
        // the low phase spans at least one full half period of the new clock
        if (new_tick && !sleep_out) begin
          next_sys_clk  = 1'b1;
          next_cur_src  = pend_src;
          next_sw_state = CKS_RUN;
        end
      end
    endcase
    next_sys_tick = next_sys_clk != sys_clk_out;
    next_sleep = sleep_out;
    next_idle  = idle_out;
    if (wake_in) begin
      next_sleep = 1'b0;
      next_idle  = 1'b0;
    end else if (sleep_req_in) begin
      next_sleep = !idle_on_sleep;
      next_idle  = idle_on_sleep;
    end
    next_clkout_oe = cks_clkout_mode(fosc);
    next_co_cnt    = co_cnt;
    next_clkout    = clock_out_pin_out && next_clkout_oe;
    if (next_clkout_oe && next_sys_tick) begin
      next_co_cnt = 2'(co_cnt + 2'h1);
      if (co_cnt == CKS_CLKOUT_HALF) begin
        next_clkout = !clock_out_pin_out;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sw_state             <= CKS_RUN;
      cur_src              <= CKS_SRC_PRI;
      pend_src             <= CKS_SRC_PRI;
      tgt_s1               <= CKS_SRC_PRI;
      tgt_s2               <= CKS_SRC_PRI;
      fail_s1              <= 1'b0;
      fail_s2              <= 1'b0;
      sys_clk_out          <= 1'b0;
      sys_tick_out         <= 1'b0;
      wdt_tick_out         <= 1'b0;
      sleep_out            <= 1'b0;
      idle_out             <= 1'b0;
      co_cnt               <= 2'h0;
      clock_out_pin_out    <= 1'b0;
      clock_out_pin_oe_out <= 1'b0;
      pll_select_out       <= 1'b0;
      pri_drive_on_out     <= CKS_DRV_RST;
      clock_fail_out       <= 1'b0;
    end else begin
      sw_state             <= next_sw_state;
      cur_src              <= next_cur_src;
      pend_src             <= next_pend_src;
      tgt_s1               <= tgt;
      tgt_s2               <= tgt_s1;
      fail_s1              <= fail_flag;
      fail_s2              <= fail_s1;
      sys_clk_out          <= next_sys_clk;
      sys_tick_out         <= next_sys_tick;
      wdt_tick_out         <= lf_tick_in;
      sleep_out            <= next_sleep;
      idle_out             <= next_idle;
      co_cnt               <= next_co_cnt;
      clock_out_pin_out    <= next_clkout;
      clock_out_pin_oe_out <= next_clkout_oe;
      pll_select_out       <= pll_sel;
      pri_drive_on_out     <= primary_drive_shutdown;
      clock_fail_out       <= fail_flag;
    end
  end

endmodule
`default_nettype wire

// *** verification/cks_clock_selector_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module cks_clock_selector_asserts
  import cks_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [11:0] paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [7:0]  primary_config_word_in,
  input wire logic        lf_tick_in,
  input wire logic        sleep_req_in,
  input wire logic        wake_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        sys_clk_out,
  input wire logic        sys_tick_out,
  input wire logic        wdt_tick_out,
  input wire logic        sleep_out,
  input wire logic        idle_out,
  input wire logic        clock_out_pin_out,
  input wire logic        clock_out_pin_oe_out,
  input wire logic        pll_select_out,
  input wire logic        clock_fail_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic acc;
  assign acc = psel_in && penable_in && !pready_out;
  logic mapped;
  assign mapped = paddr_in inside {CKS_OFS_CTRL, CKS_OFS_CTRL_B, CKS_OFS_TUNE, CKS_OFS_STAT};

  a_apb_wait_state: assert property (acc |=> pready_out)
    else $error("access not answered one cycle later");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (acc |=> pslverr_out == !$past(mapped))
    else $error("error response does not match address map");
  a_wdt_from_lf: assert property ($past(nrst_in) |=> wdt_tick_out == $past(lf_tick_in))
    else $error("watchdog tick not following low oscillator");
  a_sleep_enter: assert property (sleep_req_in && !wake_in |=> sleep_out || idle_out)
    else $error("sleep request ignored");
  a_wake_clears: assert property (wake_in |=> !sleep_out && !idle_out)
    else $error("wake did not leave low power mode");
  a_mode_exclusive: assert property (!(sleep_out && idle_out))
    else $error("sleep and idle both active");
  a_pin_quiet: assert property (!clock_out_pin_oe_out |-> !clock_out_pin_out)
    else $error("clock out driven while pin is free");
  a_tick_on_edge: assert property (sys_tick_out == $changed(sys_clk_out))
    else $error("system tick not aligned to clock toggle");
  a_no_glitch: assert property ($changed(sys_clk_out) |=> $stable(sys_clk_out))
    else $error("one cycle pulse on system clock");
  a_pll_by_fuse: assert property (!primary_config_word_in[3] && $past(nrst_in)
    |=> pll_select_out == primary_config_word_in[4])
    else $error("pll path select wrong for external mode");

  c_fail: cover property ($rose(clock_fail_out));
  c_idle: cover property ($rose(idle_out));
  c_sleep: cover property ($rose(sleep_out));
  c_err: cover property (pready_out && pslverr_out);
endmodule

bind cks_clock_selector cks_clock_selector_asserts asrt_u (.clk_in, .nrst_in, .paddr_in, .psel_in, .penable_in,
  .primary_config_word_in, .lf_tick_in, .sleep_req_in, .wake_in, .pready_out, .pslverr_out, .sys_clk_out,
  .sys_tick_out, .wdt_tick_out, .sleep_out, .idle_out, .clock_out_pin_out, .clock_out_pin_oe_out,
  .pll_select_out, .clock_fail_out);
`default_nettype wire

// *** verification/cks_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cks_osc_model #(
  parameter int PRI_P = 12,
  parameter int PLL_P = 3,
  parameter int SEC_P = 40,
  parameter int HF_P  = 2,
  parameter int MF_P  = 64,
  parameter int LF_P  = 1024
) (
  input  wire logic       clk_in,
  input  wire logic       stop_pri_in,
  output logic      [5:0] tick_out
);
  // bit order {lf, mf, hf, sec, pll, pri}; one pulse per half period
  localparam int PER [6] = '{PRI_P, PLL_P, SEC_P, HF_P, MF_P, LF_P};
  int cnt [6] = '{default: 0};

  always @(posedge clk_in) begin
    for (int i = 0; i < 6; i++) begin
      cnt[i] <= (cnt[i] + 1) % PER[i];
      // a dead crystal takes its pll down with it
      tick_out[i] <= (cnt[i] == PER[i] - 1) && !(stop_pri_in && i < 2);
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cks_pkg::*;
;
  localparam int HF_P = 2;
  // even periods put every internal tick on odd cycles, so rate changes never make a one-cycle pulse
  localparam int MF_P = 50;
  localparam int LF_P = 1024;
  localparam int PLL_P = 3;
  localparam int SEC_P = 40;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [11:0] paddr_in = '0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [31:0] pwdata_in = '0;
  logic [7:0]  primary_config_word_in = 8'h32;
  logic        sleep_req_in = 1'b0;
  logic        wake_in = 1'b0;
  logic        stop_pri = 1'b0;
  logic [5:0]  tick;
  logic [31:0] prdata_out, rdata;
  logic        pready_out, pslverr_out, sys_clk_out, sys_tick_out, wdt_tick_out, sleep_out, idle_out;
  logic        clock_out_pin_out, clock_out_pin_oe_out, pll_select_out, pri_drive_on_out, clock_fail_out;
  logic        err, co_prev;
  int          miscompares = 0;
  int          checks_done = 0;
  int          p;

  cks_osc_model #(.PLL_P(PLL_P), .SEC_P(SEC_P), .HF_P(HF_P), .MF_P(MF_P), .LF_P(LF_P)) osc_u (.clk_in,
    .stop_pri_in(stop_pri), .tick_out(tick));
  cks_clock_selector dut_u (.clk_in, .nrst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .primary_config_word_in, .pri_osc_tick_in(tick[0]),
    .pll_tick_in(tick[1]), .sec_tick_in(tick[2]), .hf_tick_in(tick[3]), .mf_tick_in(tick[4]),
    .lf_tick_in(tick[5]), .sleep_req_in, .wake_in, .sys_clk_out, .sys_tick_out, .wdt_tick_out, .sleep_out,
    .idle_out, .clock_out_pin_out, .clock_out_pin_oe_out, .pll_select_out, .pri_drive_on_out, .clock_fail_out);

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) co_prev <= clock_out_pin_out;

  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // called right after a rising edge; one idle cycle follows every transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    rdata = prdata_out;
    err = pslverr_out;
    chk(pready_out, 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rdata, exp);
  endtask

  // third interval only: the first two may straddle a setting change
  task automatic measure(input logic pin, output int q);
    for (int k = 0; k < 3; k++) begin
      q = 0;
      do begin
        @(posedge clk_in);
        q++;
      end while (!(pin ? (clock_out_pin_out !== co_prev) : (sys_tick_out === 1'b1)) && q < 5000);
    end
  endtask

  task automatic wait_switch();
    repeat (4) @(posedge clk_in);
    for (int k = 0; k < 400; k++) begin
      apb(1'b0, CKS_OFS_STAT, '0);
      if (!rdata[CKS_STAT_BUSY_BIT]) break;
    end
  endtask

  task automatic do_reset(input logic [7:0] c);
    nrst_in <= 1'b0;
    primary_config_word_in <= c;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
  endtask

  function automatic int exp_per(input logic [2:0] f, input logic med);
    if (f >= 3'h3) return HF_P << (7 - f);
    if (f == 3'h0) return LF_P;
    return med ? MF_P << (2 - f) : HF_P << (7 - f);
  endfunction

  initial begin
    logic [31:0] r;
    void'($urandom(53338));
    @(posedge clk_in);
    do_reset(8'h32);
    rdchk(CKS_OFS_CTRL, 32'h0000_0030);
    rdchk(CKS_OFS_CTRL_B, 32'h0000_0004);
    rdchk(CKS_OFS_TUNE, 32'h0000_0000);
    rdchk(CKS_OFS_STAT, 32'h0000_0005);
    chk(pll_select_out, 1'b1);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h002, '0);
    chk(err, 1'b1);
    chk(rdata, 32'h0000_0000);
    rdchk(CKS_OFS_CTRL, 32'h0000_0030);
    measure(1'b0, p);
    chk(p, PLL_P);
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      apb(1'b1, CKS_OFS_CTRL_B, r);
      rdchk(CKS_OFS_CTRL_B, r & 32'h0000_0014);
      chk(pri_drive_on_out, r[2]);
      apb(1'b1, CKS_OFS_TUNE, r >> 8);
      rdchk(CKS_OFS_TUNE, (r >> 8) & 32'h0000_00FF);
    end
    apb(1'b1, CKS_OFS_CTRL_B, 32'h0000_0004);
    apb(1'b1, CKS_OFS_TUNE, 32'h0000_0000);
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0033);
    wait_switch();
    rdchk(CKS_OFS_STAT, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, CKS_OFS_CTRL_B, 32'h04 | (m << 4));
      for (int f = 7; f >= 0; f--) begin
        apb(1'b1, CKS_OFS_CTRL, 32'h03 | (f << 4));
        measure(1'b0, p);
        chk(p, exp_per(f[2:0], m[0]));
        if (f == 0) begin
          apb(1'b1, CKS_OFS_TUNE, 32'h0000_0085);
          measure(1'b0, p);
          chk(p, m ? (16 + 5) * MF_P : (512 + 5) * HF_P);
          apb(1'b1, CKS_OFS_TUNE, 32'h0000_0000);
        end
      end
    end
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0031);
    wait_switch();
    rdchk(CKS_OFS_STAT, 32'h0000_0002);
    measure(1'b0, p);
    chk(p, SEC_P);
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0030);
    wait_switch();
    rdchk(CKS_OFS_STAT, 32'h0000_0005);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, CKS_OFS_CTRL, 32'h30 | (m << 7));
      sleep_req_in <= 1'b1;
      @(posedge clk_in);
      sleep_req_in <= 1'b0;
      @(posedge clk_in);
      chk({sleep_out, idle_out}, m ? 2'b01 : 2'b10);
      repeat (40) @(posedge clk_in);
      if (m == 0) chk(sys_clk_out, 1'b0);
      wake_in <= 1'b1;
      @(posedge clk_in);
      wake_in <= 1'b0;
      @(posedge clk_in);
      chk({sleep_out, idle_out}, 2'b00);
    end
    stop_pri <= 1'b1;
    for (int k = 0; k < 8000 && clock_fail_out !== 1'b1; k++) @(posedge clk_in);
    chk(clock_fail_out, 1'b1);
    wait_switch();
    rdchk(CKS_OFS_STAT, 32'h0000_0008);
    measure(1'b0, p);
    chk(p, exp_per(3'h3, 1'b0));
    stop_pri <= 1'b0;
    apb(1'b1, CKS_OFS_STAT, 32'h0000_0008);
    rdchk(CKS_OFS_STAT, 32'h0000_0000);
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0051);
    do_reset(8'h09);
    rdchk(CKS_OFS_CTRL, 32'h0000_0030);
    chk(clock_out_pin_oe_out, 1'b1);
    measure(1'b1, p);
    chk(p, 4 * exp_per(3'h3, 1'b0));
    chk(pll_select_out, 1'b0);
    // the pll path changes only while the primary clock is not in use; the switch sequence guards the return
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0031);
    wait_switch();
    apb(1'b1, CKS_OFS_TUNE, 32'h0000_0040);
    repeat (2) @(posedge clk_in);
    chk(pll_select_out, 1'b1);
    apb(1'b1, CKS_OFS_CTRL, 32'h0000_0030);
    wait_switch();
    rdchk(CKS_OFS_STAT, 32'h0000_0004);
    measure(1'b0, p);
    chk(p, PLL_P);
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
